//--- hpc_pkg.sv
// host port configuration package: register map, field positions, reset values, carriers
// assumes a 24-bit core peripheral address and a 16-bit core data path
// Notes on behaviour
// R1 - in multiplexed mode, host address matching the base field raises internal select
// R2 - base field is bits 7..0 of the base register, reset value 80 hex
// R3 - base register bits 15..8 read zero; software writes only zero there
// R4 - port control register is read/write by the core and sets the port mode
// R5 - hardware reset and software reset clear every port control bit
// R6 - software changes polarity, strobe, mux, drain, enables only while port disabled
// R7 - software never sets those bits while enabled or in the enabling write
// R8 - bit 15 picks acknowledge polarity; acknowledge drives the vector onto host bus
// R9 - bit 14 picks single request output polarity while requests are enabled
// R10 - bit 14 likewise sets both transmit and receive request polarity in double mode
// R11 - bit 13 picks chip-select polarity: clear selects on low, set on high
// R12 - bit 12 clear: one data strobe serves both reads and writes
// R13 - bit 12 set: separate read strobe and write strobe
// R14 - port enable set makes block the host interface; clear leaves pins as GPIO
// R15 - mux bit set latches low address from the bus, else dedicated pins used
// R16 - self select compares host address bits 10..3 with base bits one to one
// R17 - select, acknowledge and request polarities act only while port is enabled
package hpc_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REG_ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFS_PORT_CTRL = 24'hFFFFC4;
    localparam logic [ADDR_W-1:0] OFS_BASE_ADDR = 24'hFFFFC5;
    localparam logic [DATA_W-1:0] PORT_CTRL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] BASE_ADDR_RST = 16'h0080;
    // writable bits; reserved bits are stored and read as zero
    localparam logic [DATA_W-1:0] PORT_CTRL_MASK = 16'hFF7F;
    localparam logic [DATA_W-1:0] BASE_ADDR_MASK = 16'h00FF;
    localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
    // port control fields
    localparam int B_ACK_POL = 15;
    localparam int B_REQ_POL = 14;
    localparam int B_SEL_POL = 13;
    localparam int B_DUAL_STB = 12;
    localparam int B_MUX = 11;
    localparam int B_ASTB_POL = 10;
    localparam int B_DSTB_POL = 9;
    localparam int B_REQ_OD = 8;
    localparam int B_PORT_EN = 6;
    localparam int B_ACK_EN = 5;
    localparam int B_REQ_EN = 4;
    // host address bits compared against the base field
    localparam int CMP_HI = 10;
    localparam int CMP_LO = 3;
    localparam int BASE_W = CMP_HI - CMP_LO + 1;

    // host-side pins, sampled together through one synchroniser
    typedef struct packed {
        logic [DATA_W-1:0] ad;
        logic [REG_ADDR_W-1:0] addr;
        logic cs;
        logic ack;
        logic astb;
        logic stb_a;
        logic stb_b;
    } hpc_pins_t;

    // request pin drive: level and enable
    typedef struct packed {
        logic lvl;
        logic oe;
    } hpc_drive_t;
endpackage : hpc_pkg

//--- hpc_port.sv
// host port configuration and self chip-select logic
// assumes host pins are asynchronous; core-side strobes and request sources are on sys_clk_in
`timescale 1ns/1ps
module hpc_port
    import hpc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic sw_rst_in,
    input wire logic [ADDR_W-1:0] core_addr_in,
    input wire logic core_wr_in,
    input wire logic core_rd_in,
    input wire logic [DATA_W-1:0] core_wdata_in,
    output logic [DATA_W-1:0] core_rdata_out,
    input wire logic double_request_mode_in,
    input wire logic host_req_in,
    input wire logic tx_req_in,
    input wire logic rx_req_in,
    input wire logic [DATA_W-1:0] interrupt_vector_reg_in,
    input wire hpc_pins_t host_pins_in,
    output logic port_enable_out,
    output logic port_selected_out,
    output logic host_rd_out,
    output logic host_wr_out,
    output logic [REG_ADDR_W-1:0] host_reg_addr_out,
    output logic [DATA_W-1:0] host_data_out,
    output logic host_data_oe_out,
    output logic req0_pin_out,
    output logic req0_oe_out,
    output logic req1_pin_out,
    output logic req1_oe_out
);
    // pin polarity: a pin is active when its level equals the polarity bit
    function automatic logic active(input logic pin, input logic pol);
        return pin == pol;
    endfunction : active

    // request pin drive; open drain only ever pulls low
    function automatic hpc_drive_t req_drive(input logic req, input logic pol,
                                             input logic od, input logic en);
        hpc_drive_t d;
        d.lvl = req ? pol : ~pol;
        d.oe = en & (~od | ~d.lvl);
        return d;
    endfunction : req_drive

    logic [DATA_W-1:0] port_ctrl_r, port_ctrl_nxt;
    logic [DATA_W-1:0] base_addr_r, base_addr_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    hpc_pins_t pins_meta_r, pins_r;
    logic [DATA_W-1:0] ad_latch_r, ad_latch_nxt;
    logic sel_r, sel_nxt;
    logic rd_r, rd_nxt;
    logic wr_r, wr_nxt;
    logic [REG_ADDR_W-1:0] reg_addr_r, reg_addr_nxt;
    logic [DATA_W-1:0] hdata_r, hdata_nxt;
    logic hdata_oe_r, hdata_oe_nxt;
    hpc_drive_t req0_r, req0_nxt, req1_r, req1_nxt;
    logic en, muxed, base_hit, pin_sel, ack_act, stb_rd, stb_wr, req_en;

    // two-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pins_meta_r <= '0;
            pins_r <= '0;
        end else begin
            pins_meta_r <= host_pins_in;
            pins_r <= pins_meta_r;
        end
    end

    // register file next values; software reset wins over a same-cycle write
    always_comb begin
        port_ctrl_nxt = port_ctrl_r;
        base_addr_nxt = base_addr_r;
        rdata_nxt = rdata_r;
        if (core_wr_in && core_addr_in == OFS_PORT_CTRL)
            port_ctrl_nxt = core_wdata_in & PORT_CTRL_MASK; // R4
        if (core_wr_in && core_addr_in == OFS_BASE_ADDR)
            base_addr_nxt = core_wdata_in & BASE_ADDR_MASK; // R2 R3
        if (sw_rst_in) begin
            port_ctrl_nxt = PORT_CTRL_RST; // R5
            base_addr_nxt = BASE_ADDR_RST;
        end
        if (core_rd_in) begin
            unique case (core_addr_in)
                OFS_PORT_CTRL: rdata_nxt = port_ctrl_r; // R4
                OFS_BASE_ADDR: rdata_nxt = base_addr_r; // R3
                default: rdata_nxt = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_ctrl_r <= PORT_CTRL_RST; // R5
            base_addr_r <= BASE_ADDR_RST; // R2
            rdata_r <= '0;
        end else begin
            port_ctrl_r <= port_ctrl_nxt;
            base_addr_r <= base_addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // decoded mode; every pin function except the register address is gated by the port enable
    assign en = port_ctrl_r[B_PORT_EN]; // R14
    assign muxed = port_ctrl_r[B_MUX];
    assign req_en = en & port_ctrl_r[B_REQ_EN];
    // R16: one-to-one compare of host address bits against the base field
    assign base_hit = ad_latch_r[CMP_HI:CMP_LO] == base_addr_r[BASE_W-1:0]; // R16
    // muxed bus decodes its own select, otherwise the select pin counts
    assign pin_sel = muxed ? base_hit // R1
                           : active(pins_r.cs, port_ctrl_r[B_SEL_POL]); // R11
    // acknowledge only exists in single-request mode with both enables
    assign ack_act = req_en & port_ctrl_r[B_ACK_EN] & ~double_request_mode_in
                   & active(pins_r.ack, port_ctrl_r[B_ACK_POL]); // R8 R17
    // single mode: stb_a is the data strobe and stb_b high means read
    // dual mode: stb_a is the write strobe and stb_b the read strobe
    always_comb begin
        stb_rd = 1'b0;
        stb_wr = 1'b0;
        if (port_ctrl_r[B_DUAL_STB]) begin
            stb_wr = active(pins_r.stb_a, port_ctrl_r[B_DSTB_POL]); // R13
            stb_rd = active(pins_r.stb_b, port_ctrl_r[B_DSTB_POL]); // R13
        end else if (active(pins_r.stb_a, port_ctrl_r[B_DSTB_POL])) begin
            stb_rd = pins_r.stb_b; // R12
            stb_wr = ~pins_r.stb_b; // R12
        end
    end

    // host path next values
    always_comb begin
        ad_latch_nxt = ad_latch_r;
        // transparent while the address strobe is active, holds after it
        if (en && muxed && active(pins_r.astb, port_ctrl_r[B_ASTB_POL]))
            ad_latch_nxt = pins_r.ad; // R15
        sel_nxt = en & pin_sel; // R17
        rd_nxt = en & pin_sel & stb_rd;
        wr_nxt = en & pin_sel & stb_wr;
        reg_addr_nxt = muxed ? ad_latch_r[REG_ADDR_W-1:0] : pins_r.addr; // R15
        hdata_oe_nxt = ack_act; // R8
        hdata_nxt = ack_act ? interrupt_vector_reg_in : hdata_r; // R8
        if (double_request_mode_in) begin
            req0_nxt = req_drive(tx_req_in, port_ctrl_r[B_REQ_POL],
                                 port_ctrl_r[B_REQ_OD], req_en); // R10
            req1_nxt = req_drive(rx_req_in, port_ctrl_r[B_REQ_POL],
                                 port_ctrl_r[B_REQ_OD], req_en); // R10
        end else begin
            req0_nxt = req_drive(host_req_in, port_ctrl_r[B_REQ_POL],
                                 port_ctrl_r[B_REQ_OD], req_en); // R9
            req1_nxt = '0; // second pin is the acknowledge input here
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ad_latch_r <= '0;
            sel_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            reg_addr_r <= '0;
            hdata_r <= '0;
            hdata_oe_r <= 1'b0;
            req0_r <= '0;
            req1_r <= '0;
        end else begin
            ad_latch_r <= ad_latch_nxt;
            sel_r <= sel_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            reg_addr_r <= reg_addr_nxt;
            hdata_r <= hdata_nxt;
            hdata_oe_r <= hdata_oe_nxt;
            req0_r <= req0_nxt;
            req1_r <= req1_nxt;
        end
    end

    // outputs straight from flops
    assign core_rdata_out = rdata_r;
    assign port_enable_out = en;
    assign port_selected_out = sel_r;
    assign host_rd_out = rd_r;
    assign host_wr_out = wr_r;
    assign host_reg_addr_out = reg_addr_r;
    assign host_data_out = hdata_r;
    assign host_data_oe_out = hdata_oe_r;
    assign req0_pin_out = req0_r.lvl;
    assign req0_oe_out = req0_r.oe;
    assign req1_pin_out = req1_r.lvl;
    assign req1_oe_out = req1_r.oe;

    // checks on the register file and the host decode
    property p_base_reset;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        sw_rst_in |=> base_addr_r == BASE_ADDR_RST && port_ctrl_r == PORT_CTRL_RST;
    endproperty
    a_base_reset: assert property (p_base_reset) else $error("soft reset value wrong"); // R5

    property p_base_reserved;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        core_rd_in && core_addr_in == OFS_BASE_ADDR |=> rdata_r[DATA_W-1:BASE_W] == '0;
    endproperty
    a_base_reserved: assert property (p_base_reserved) else $error("reserved bits set"); // R3

    property p_ctrl_write;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        core_wr_in && !sw_rst_in && core_addr_in == OFS_PORT_CTRL
            |=> port_ctrl_r == ($past(core_wdata_in) & PORT_CTRL_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R4

    property p_base_write;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        core_wr_in && !sw_rst_in && core_addr_in == OFS_BASE_ADDR
            ##1 core_rd_in && !core_wr_in && !sw_rst_in && core_addr_in == OFS_BASE_ADDR
            |=> rdata_r == ($past(core_wdata_in, 2) & BASE_ADDR_MASK);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base readback wrong"); // R2

    property p_self_select;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        en && muxed && ad_latch_r[CMP_HI:CMP_LO] == base_addr_r[BASE_W-1:0] |=> sel_r;
    endproperty
    a_self_select: assert property (p_self_select) else $error("no self select"); // R1 R16

    property p_disabled_quiet;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !en [*2] |-> !sel_r && !rd_r && !wr_r && !req0_r.oe && !hdata_oe_r;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("active while off"); // R14 R17

    property p_pin_select;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        en && !muxed |=> sel_r == ($past(pins_r.cs) == $past(port_ctrl_r[B_SEL_POL]));
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("select polarity"); // R11

    property p_ack_vector;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        ack_act |=> hdata_oe_r && hdata_r == $past(interrupt_vector_reg_in);
    endproperty
    a_ack_vector: assert property (p_ack_vector) else $error("vector not driven"); // R8

    property p_req_level;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        req_en && !double_request_mode_in |=>
            req0_r.lvl == ($past(host_req_in) == $past(port_ctrl_r[B_REQ_POL]));
    endproperty
    a_req_level: assert property (p_req_level) else $error("request polarity"); // R9

    property p_dual_req;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        req_en && double_request_mode_in |=>
            req1_r.lvl == ($past(rx_req_in) == $past(port_ctrl_r[B_REQ_POL]));
    endproperty
    a_dual_req: assert property (p_dual_req) else $error("receive request polarity"); // R10

    property p_single_strobe;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !port_ctrl_r[B_DUAL_STB] |=> !(rd_r && wr_r);
    endproperty
    a_single_strobe: assert property (p_single_strobe) else $error("both strobes"); // R12

    property p_dual_strobe;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        en && pin_sel && port_ctrl_r[B_DUAL_STB] |=>
            rd_r == $past(pins_r.stb_b == port_ctrl_r[B_DSTB_POL]);
    endproperty
    a_dual_strobe: assert property (p_dual_strobe) else $error("read strobe"); // R13

    property p_mux_addr;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !muxed |=> reg_addr_r == $past(pins_r.addr);
    endproperty
    a_mux_addr: assert property (p_mux_addr) else $error("address source"); // R15

    // latch must not drift while the address strobe is idle, whatever the mode
    property p_latch_hold;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !active(pins_r.astb, port_ctrl_r[B_ASTB_POL]) |=> ad_latch_r == $past(ad_latch_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch not held"); // R15

    property p_single_dir;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        en && pin_sel && !port_ctrl_r[B_DUAL_STB]
            && active(pins_r.stb_a, port_ctrl_r[B_DSTB_POL])
            |=> rd_r == $past(pins_r.stb_b) && wr_r == !$past(pins_r.stb_b);
    endproperty
    a_single_dir: assert property (p_single_dir) else $error("single strobe direction"); // R12

    property p_off_outputs;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !en |=> !sel_r && !hdata_oe_r && !req0_r.oe && !req1_r.oe;
    endproperty
    a_off_outputs: assert property (p_off_outputs) else $error("active while off"); // R17

    c_self_select: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        en && muxed ##1 sel_r ##1 rd_r);
    c_ack: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) hdata_oe_r);
    c_dual_write: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        port_ctrl_r[B_DUAL_STB] && wr_r);
    c_double_req: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
        double_request_mode_in && req1_r.oe);
endmodule : hpc_port

//--- hpc_host_model.sv
// host processor model: drives the host side pins of the port
// assumes the bench calls put just after a rising edge; pins are plain levels
`timescale 1ns/1ps
module hpc_host_model
    import hpc_pkg::*;
(
    input wire logic sys_clk_in,
    output hpc_pins_t pins_out
);
    // idle: every strobe, select and acknowledge at its high level
    initial begin
        pins_out = '{ad: 16'h0000, addr: 3'h0, cs: 1'b1, ack: 1'b1, astb: 1'b1,
                     stb_a: 1'b1, stb_b: 1'b1};
    end

    // one host bus state, changed at a rising edge and held until the next call
    task automatic put(input logic [15:0] ad, input logic [2:0] addr, input logic cs,
                       input logic ack, input logic astb, input logic sa, input logic sb);
        @(posedge sys_clk_in);
        pins_out <= '{ad: ad, addr: addr, cs: cs, ack: ack, astb: astb,
                      stb_a: sa, stb_b: sb};
    endtask : put
endmodule : hpc_host_model

//--- hpc_port_tb_top.sv
// self-checking bench for the host port configuration block
// assumes the host model stands in for the external host processor
`timescale 1ns/1ps
module hpc_port_tb_top;
    import hpc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic sw_rst_in = 1'b0;
    logic [ADDR_W-1:0] core_addr_in = 24'h000000;
    logic core_wr_in = 1'b0;
    logic core_rd_in = 1'b0;
    logic [DATA_W-1:0] core_wdata_in = 16'h0000;
    logic [DATA_W-1:0] core_rdata_out;
    logic double_request_mode_in = 1'b0;
    logic host_req_in = 1'b0;
    logic tx_req_in = 1'b0;
    logic rx_req_in = 1'b0;
    logic [DATA_W-1:0] interrupt_vector_reg_in = 16'hA5C3;
    hpc_pins_t host_pins_in;
    logic port_enable_out, port_selected_out, host_rd_out, host_wr_out, host_data_oe_out;
    logic [REG_ADDR_W-1:0] host_reg_addr_out;
    logic [DATA_W-1:0] host_data_out;
    logic req0_pin_out, req0_oe_out, req1_pin_out, req1_oe_out;
    int error_cnt = 0;
    int comparisons = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    hpc_host_model u_host (.sys_clk_in, .pins_out(host_pins_in));
    hpc_port u_dut (.sys_clk_in, .nrst_in, .sw_rst_in, .core_addr_in, .core_wr_in,
        .core_rd_in, .core_wdata_in, .core_rdata_out, .double_request_mode_in,
        .host_req_in, .tx_req_in, .rx_req_in, .interrupt_vector_reg_in, .host_pins_in,
        .port_enable_out, .port_selected_out, .host_rd_out, .host_wr_out,
        .host_reg_addr_out, .host_data_out, .host_data_oe_out, .req0_pin_out,
        .req0_oe_out, .req1_pin_out, .req1_oe_out);

    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // core write: strobe for one cycle, then one idle edge before the next access
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        core_addr_in <= a;
        core_wdata_in <= d;
        core_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        core_wr_in <= 1'b0;
    endtask : wr

    // core read: data is registered, so look one edge after the strobe is taken
    task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string what);
        @(posedge sys_clk_in);
        core_addr_in <= a;
        core_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        core_rd_in <= 1'b0;
        @(posedge sys_clk_in);
        #1 chk(what, core_rdata_out, exp);
    endtask : rd

    // mode bits change only with the port disabled, enable comes in a later write
    task automatic cfg(input logic [15:0] bits);
        wr(OFS_PORT_CTRL, 16'h0000);
        wr(OFS_PORT_CTRL, bits);
        wr(OFS_PORT_CTRL, bits | 16'h0040);
    endtask : cfg

    // host pins pass two sync flops, the address latch when muxed, and an output register
    task automatic settle();
        repeat (4) @(posedge sys_clk_in);
        #1;
    endtask : settle

    // strobe table: control bits, strobe a, strobe b, expected read, expected write
    logic [19:0] stb_tab [5] = '{{16'h0000, 4'b0110}, {16'h0000, 4'b0001},
                                 {16'h1000, 4'b0101}, {16'h1000, 4'b1010},
                                 {16'h0200, 4'b1001}};

    initial begin
        #100us;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd(OFS_PORT_CTRL, PORT_CTRL_RST, "control reset");
        rd(OFS_BASE_ADDR, 16'h0080, "base reset");
        wr(OFS_BASE_ADDR, 16'hFF12);
        rd(OFS_BASE_ADDR, 16'h0012, "base upper bits");
        // write and read back on consecutive edges
        @(posedge sys_clk_in);
        core_addr_in <= OFS_BASE_ADDR;
        core_wdata_in <= 16'h0033;
        core_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        core_wr_in <= 1'b0;
        core_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        core_rd_in <= 1'b0;
        @(posedge sys_clk_in);
        #1 chk("base back to back", core_rdata_out, 16'h0033);
        wr(OFS_PORT_CTRL, 16'hBFBF);
        rd(OFS_PORT_CTRL, 16'hBF3F, "control read back");
        rd(24'hFFFFC6, 16'h0000, "unmapped read");
        @(posedge sys_clk_in);
        sw_rst_in <= 1'b1;
        @(posedge sys_clk_in);
        sw_rst_in <= 1'b0;
        rd(OFS_PORT_CTRL, 16'h0000, "control soft reset");
        // dedicated select pin, both polarities, then disabled
        cfg(16'h0000);
        #1 chk("enable", 16'(port_enable_out), 16'h0001);
        u_host.put(16'h0000, 3'h5, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        settle();
        chk("select low", 16'(port_selected_out), 16'h0001);
        chk("dedicated addr", 16'(host_reg_addr_out), 16'h0005);
        u_host.put(16'h0000, 3'h5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        settle();
        chk("select high off", 16'(port_selected_out), 16'h0000);
        cfg(16'h2000);
        settle();
        chk("select high", 16'(port_selected_out), 16'h0001);
        wr(OFS_PORT_CTRL, 16'h2000);
        settle();
        chk("select disabled", 16'(port_selected_out), 16'h0000);
        chk("disable", 16'(port_enable_out), 16'h0000);
        // single and dual strobe decoding with the port selected
        for (int i = 0; i < 5; i++) begin
            cfg(stb_tab[i][19:4]);
            u_host.put(16'h0000, 3'h0, 1'b0, 1'b1, 1'b1, stb_tab[i][3], stb_tab[i][2]);
            settle();
            chk("host read", 16'(host_rd_out), 16'(stb_tab[i][1]));
            chk("host write", 16'(host_wr_out), 16'(stb_tab[i][0]));
        end
        // multiplexed bus: latched address against base 55 hex, select pin held off
        wr(OFS_BASE_ADDR, 16'h0055);
        cfg(16'h0800);
        u_host.put(16'h02AB, 3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        settle();
        chk("mux match", 16'(port_selected_out), 16'h0001);
        chk("latched addr", 16'(host_reg_addr_out), 16'h0003);
        u_host.put(16'h0000, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        settle();
        chk("latch hold", 16'(port_selected_out), 16'h0001);
        for (int k = 3; k <= 10; k++) begin
            u_host.put(16'h02A8 ^ (16'h0001 << k), 3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
            settle();
            chk("mux miss", 16'(port_selected_out), 16'h0000);
        end
        // request outputs, single then double mode, both polarities, open drain
        cfg(16'h0010);
        @(posedge sys_clk_in);
        host_req_in <= 1'b1;
        settle();
        chk("req low active", 16'({req0_oe_out, req0_pin_out}), 16'h0002);
        cfg(16'h4010);
        settle();
        chk("req high active", 16'({req0_oe_out, req0_pin_out}), 16'h0003);
        cfg(16'h0110);
        settle();
        chk("req drain pull", 16'({req0_oe_out, req0_pin_out}), 16'h0002);
        @(posedge sys_clk_in);
        host_req_in <= 1'b0;
        settle();
        chk("req drain release", 16'({req0_oe_out, req0_pin_out}), 16'h0001);
        @(posedge sys_clk_in);
        double_request_mode_in <= 1'b1;
        tx_req_in <= 1'b1;
        cfg(16'h0010);
        settle();
        chk("tx req", 16'({req0_oe_out, req0_pin_out}), 16'h0002);
        chk("rx req", 16'({req1_oe_out, req1_pin_out}), 16'h0003);
        wr(OFS_PORT_CTRL, 16'h0010);
        settle();
        chk("req disabled", 16'({req0_oe_out, req1_oe_out}), 16'h0000);
        // acknowledge puts the vector out; host model still drives 5A3C on the data lines
        @(posedge sys_clk_in);
        double_request_mode_in <= 1'b0;
        cfg(16'h0030);
        u_host.put(16'h5A3C, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        settle();
        chk("ack low oe", 16'(host_data_oe_out), 16'h0001);
        chk("vector", host_data_out, 16'hA5C3);
        cfg(16'h8030);
        settle();
        chk("ack high off", 16'(host_data_oe_out), 16'h0000);
        u_host.put(16'h5A3C, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        settle();
        chk("ack high oe", 16'(host_data_oe_out), 16'h0001);
        summarize();
    end
endmodule : hpc_port_tb_top
